//--- rtl/bexp_unit.sv
// Exception prioritisation and data bus error reporting of the core
`timescale 1ns/1ps
`default_nettype none
module bexp_unit
    import bexp_pkg::*;
(
    // Clock and reset
    input  wire logic          mclk,
    input  wire logic          nrst,
    // Enable values, loaded into flops while enableWrite is high
    input  wire logic          busTimeoutEnable,
    input  wire logic          multibitErrorBusEnable,
    input  wire logic          initiatorReadBusErrorEnable,
    input  wire logic          enableWrite,
    // Exception requests from the pipeline, one bit per source code
    input  wire logic [15:0]   excReq,
    // Load tracking
    input  wire logic          loadIssue,
    input  wire logic          loadDataReturn,
    input  wire logic          nextDependsOnLoad,
    input  wire logic          syncAfterLoad,
    // Bus error sources
    input  wire logic          timeoutEvt,
    input  wire logic          timeoutWrite,
    input  wire bexp_master_t  timeoutMaster,
    input  wire logic          eccEvt,
    input  wire logic          eccWrite,
    input  wire bexp_master_t  eccMaster,
    input  wire logic [4:0]    pciReadFault,
    // Exception result
    output logic               excValid,
    output bexp_code_t         excCode,
    output logic               excAsync,
    output logic               dataBusErrorDropped,
    // Pipeline control and system bus error
    output logic               pipeStall,
    output logic               sysBusError
);
    logic         toEn_q;
    logic         mbEn_q;
    logic         irEn_q;
    logic         loadPend_q;
    logic         syncHold_q;
    logic         coreReadBusError;
    logic         otherBusError;
    logic [15:0]  req;
    logic [15:0]  firstOne;
    bexp_code_t   winner;
    logic         anyReq;
    logic         stall_d;

    // ==========================================================
    // Enables: reset values, then software-driven updates
    always_ff @(posedge mclk)
    begin
        if (!nrst)
        begin
            toEn_q <= RST_BUS_TIMEOUT_ENABLE;
            mbEn_q <= RST_MULTIBIT_BUS_ENABLE;
            irEn_q <= RST_INIT_READ_BUS_ENABLE;
        end
        else if (enableWrite)
        begin
            toEn_q <= busTimeoutEnable;
            mbEn_q <= multibitErrorBusEnable;
            irEn_q <= initiatorReadBusErrorEnable;
        end
    end

    // ==========================================================
    // Bus error gathering
    bexp_error_gather u_gather (
        .mclk                        (mclk),
        .nrst                        (nrst),
        .busTimeoutEnable            (toEn_q),
        .multibitErrorBusEnable      (mbEn_q),
        .initiatorReadBusErrorEnable (irEn_q),
        .timeoutEvt                  (timeoutEvt),
        .timeoutWrite                (timeoutWrite),
        .timeoutMaster               (timeoutMaster),
        .eccEvt                      (eccEvt),
        .eccWrite                    (eccWrite),
        .eccMaster                   (eccMaster),
        .pciReadFault                (pciReadFault),
        .coreReadBusError            (coreReadBusError),
        .otherBusError               (otherBusError)
    );

    // ==========================================================
    // Load tracking: a pending load only reports while outstanding
    always_ff @(posedge mclk)
    begin
        if (!nrst)
            loadPend_q <= 1'b0;
        else if (loadIssue)
            loadPend_q <= 1'b1;
        else if (loadDataReturn)
            loadPend_q <= 1'b0;
    end

    // Sync right after a load holds until the data is back
    always_ff @(posedge mclk)
    begin
        if (!nrst)
            syncHold_q <= 1'b0;
        else if (syncAfterLoad && loadPend_q && !loadDataReturn)
            syncHold_q <= 1'b1;
        else if (loadDataReturn)
            syncHold_q <= 1'b0;
    end

    // Only a dependent instruction or an armed sync stalls the pipe
    assign stall_d = loadPend_q & !loadDataReturn
                   & (nextDependsOnLoad | syncAfterLoad | syncHold_q);

    // ==========================================================
    // Priority resolution; core read errors join as a data bus error
    always_comb
    begin
        req = excReq;
        req[BEXP_DATA_BUS_ERROR] = excReq[BEXP_DATA_BUS_ERROR]
                                 | (coreReadBusError & loadPend_q);
        req[BEXP_NONE] = 1'b0;
    end

    // Lowest set index wins, index order is priority
    assign firstOne = req & (~req + 16'h0001);
    assign anyReq   = |req;

    always_comb
    begin
        winner = BEXP_NONE;
        for (int i = BEXP_NSRC - 2; i >= 0; i--)
        begin
            if (firstOne[i])
                winner = bexp_code_t'(i[BEXP_CW-1:0]);
        end
    end

    // ==========================================================
    // Outputs, registered
    always_ff @(posedge mclk)
    begin
        if (!nrst)
        begin
            excValid            <= 1'b0;
            excCode             <= BEXP_NONE;
            excAsync            <= 1'b0;
            dataBusErrorDropped <= 1'b0;
        end
        else
        begin
            excValid   <= anyReq;
            excCode    <= winner;
            excAsync   <= anyReq & BEXP_ASYNC_MASK[winner];
            // A higher exception swallows the bus error, which is not replayed
            dataBusErrorDropped <= req[BEXP_DATA_BUS_ERROR]
                                && winner != BEXP_DATA_BUS_ERROR;
        end
    end

    always_ff @(posedge mclk)
    begin
        if (!nrst)
        begin
            pipeStall   <= 1'b0;
            sysBusError <= 1'b0;
        end
        else
        begin
            pipeStall   <= stall_d;
            sysBusError <= otherBusError;
        end
    end

    // ==========================================================
    // Checks
    // Priority order, checked at the top, the middle and the bottom of the list
    top_priority_a: assert property (@(posedge mclk) disable iff (!nrst)
        excReq[BEXP_COLD_RESET] |=> (excValid && excCode == BEXP_COLD_RESET))
        else $error("cold reset not first");
    soft_reset_a: assert property (@(posedge mclk) disable iff (!nrst)
        (excReq[BEXP_SOFT_RESET] && !excReq[BEXP_COLD_RESET])
        |=> (excValid && excCode == BEXP_SOFT_RESET && excAsync))
        else $error("soft reset not second");
    fetch_bus_a: assert property (@(posedge mclk) disable iff (!nrst)
        (excReq[BEXP_FETCH_BUS_ERROR] && excReq[2:0] == 3'h0)
        |=> (excCode == BEXP_FETCH_BUS_ERROR && excAsync))
        else $error("fetch bus error misplaced");
    nmi_over_buserr_a: assert property (@(posedge mclk) disable iff (!nrst)
        (excReq[BEXP_NMI] && excReq[BEXP_DATA_BUS_ERROR] && excReq[2:0] == 3'h4)
        |=> (excCode == BEXP_NMI && dataBusErrorDropped))
        else $error("nmi lost to data bus error");
    buserr_alone_a: assert property (@(posedge mclk) disable iff (!nrst)
        (excReq[BEXP_DATA_BUS_ERROR] && excReq[9:0] == 10'h000)
        |=> (excCode == BEXP_DATA_BUS_ERROR && excAsync && !dataBusErrorDropped))
        else $error("data bus error dropped alone");
    sync_class_a: assert property (@(posedge mclk) disable iff (!nrst)
        (excValid && excCode == BEXP_LOAD_ADDRESS_ERROR) |-> !excAsync)
        else $error("address error marked async");
    async_class_a: assert property (@(posedge mclk) disable iff (!nrst)
        (excValid && excCode == BEXP_INTERRUPT) |-> excAsync)
        else $error("interrupt marked sync");
    fetch_tlb_a: assert property (@(posedge mclk) disable iff (!nrst)
        (excReq[14:0] == 15'h4000 && !coreReadBusError)
        |=> (excValid && excCode == BEXP_FETCH_TLB_INVALID && !excAsync))
        else $error("fetch tlb invalid misplaced");
    idle_quiet_a: assert property (@(posedge mclk) disable iff (!nrst)
        (excReq[14:0] == 15'h0000 && !coreReadBusError)
        |=> (!excValid && excCode == BEXP_NONE && !dataBusErrorDropped))
        else $error("exception without request");
    // Load stalls: only dependence or an armed sync may hold the pipe
    no_stall_a: assert property (@(posedge mclk) disable iff (!nrst)
        (!nextDependsOnLoad && !syncAfterLoad && !syncHold_q) |=> !pipeStall)
        else $error("independent instruction stalled");
    dep_stall_a: assert property (@(posedge mclk) disable iff (!nrst)
        (nextDependsOnLoad && loadPend_q && !loadDataReturn) |=> pipeStall)
        else $error("dependent instruction not stalled");
    sync_hold_a: assert property (@(posedge mclk) disable iff (!nrst)
        (syncAfterLoad && loadPend_q && !loadDataReturn && !loadIssue)
        ##1 !loadDataReturn |=> pipeStall) else $error("sync did not hold");
    return_release_a: assert property (@(posedge mclk) disable iff (!nrst)
        loadDataReturn |=> !pipeStall) else $error("stall after load data");
    core_buserr_a: assert property (@(posedge mclk) disable iff (!nrst)
        (coreReadBusError && loadPend_q && excReq[9:0] == 10'h000)
        |=> (excValid && excCode == BEXP_DATA_BUS_ERROR))
        else $error("core read error not a data bus error");
    sys_error_a: assert property (@(posedge mclk) disable iff (!nrst)
        otherBusError |=> sysBusError) else $error("system bus error lost");
endmodule
`default_nettype wire

//--- shared/bexp_pkg.sv
// Package with constants and types of the exception priority and bus error unit
package bexp_pkg;

    // ==========================================================
    // Exception sources, index order is priority, 0 highest
    localparam int BEXP_NSRC = 16;
    localparam int BEXP_CW   = 4;

    typedef enum logic [3:0] {
        BEXP_COLD_RESET,
        BEXP_SOFT_RESET,
        BEXP_NMI,
        BEXP_FETCH_BUS_ERROR,
        BEXP_ARITH_TRAP,
        BEXP_LOAD_ADDRESS_ERROR,
        BEXP_STORE_ADDRESS_ERROR,
        BEXP_DATA_TLB_REFILL,
        BEXP_DATA_TLB_INVALID,
        BEXP_DATA_TLB_MODIFY,
        BEXP_DATA_BUS_ERROR,
        BEXP_INTERRUPT,
        BEXP_FETCH_ADDRESS_ERROR,
        BEXP_FETCH_TLB_REFILL,
        BEXP_FETCH_TLB_INVALID,
        BEXP_NONE
    } bexp_code_t;

    // Sources asynchronous to the instruction stream, bit per source
    localparam logic [15:0] BEXP_ASYNC_MASK = 16'h0c0f;

    // ==========================================================
    // Bus master identity
    typedef enum logic [1:0] {
        BEXP_MST_CORE,
        BEXP_MST_DMA,
        BEXP_MST_PCI,
        BEXP_MST_OTHER
    } bexp_master_t;

    // ==========================================================
    // Reset values of the enables
    localparam logic RST_BUS_TIMEOUT_ENABLE    = 1'b0;
    localparam logic RST_MULTIBIT_BUS_ENABLE   = 1'b0;
    localparam logic RST_INIT_READ_BUS_ENABLE  = 1'b1;

endpackage

//--- rtl/bexp_error_gather.sv
// Gathers the enabled bus-error sources of the internal bus
`timescale 1ns/1ps
`default_nettype none
module bexp_error_gather
    import bexp_pkg::*;
(
    // Clock and reset
    input  wire logic          mclk,
    input  wire logic          nrst,
    // Enables
    input  wire logic          busTimeoutEnable,
    input  wire logic          multibitErrorBusEnable,
    input  wire logic          initiatorReadBusErrorEnable,
    // Timeout monitor
    input  wire logic          timeoutEvt,
    input  wire logic          timeoutWrite,
    input  wire bexp_master_t  timeoutMaster,
    // SDRAM checker
    input  wire logic          eccEvt,
    input  wire logic          eccWrite,
    input  wire bexp_master_t  eccMaster,
    // PCI initiator read faults: parity, master abort, target abort, trdy, retry
    input  wire logic [4:0]    pciReadFault,
    // Results, registered
    output logic               coreReadBusError,
    output logic               otherBusError
);
    logic toErr;
    logic eccErr;
    logic pciErr;
    logic toCore;
    logic eccCore;

    // ==========================================================
    // Source qualification
    assign toErr   = busTimeoutEnable & timeoutEvt
                   & (!timeoutWrite | (timeoutMaster != BEXP_MST_CORE));
    // A core write is never reported, so a core timeout here is a read
    assign toCore  = toErr & (timeoutMaster == BEXP_MST_CORE);
    // Core SDRAM writes are not in the error set; only its reads count
    assign eccErr  = multibitErrorBusEnable & eccEvt
                   & (!eccWrite | (eccMaster != BEXP_MST_CORE));
    assign eccCore = eccErr & (eccMaster == BEXP_MST_CORE);
    assign pciErr  = initiatorReadBusErrorEnable & (|pciReadFault);

    // Register the combined indications
    always_ff @(posedge mclk)
    begin
        if (!nrst)
        begin
            coreReadBusError <= 1'b0;
            otherBusError    <= 1'b0;
        end
        else
        begin
            coreReadBusError <= toCore | eccCore;
            otherBusError    <= (toErr & !toCore) | (eccErr & !eccCore) | pciErr;
        end
    end

    // ==========================================================
    // Checks
    core_write_quiet_a: assert property (@(posedge mclk) disable iff (!nrst)
        (timeoutEvt && timeoutWrite && timeoutMaster == BEXP_MST_CORE && !eccEvt)
        |=> !coreReadBusError) else $error("core write timeout reported");
    timeout_off_a: assert property (@(posedge mclk) disable iff (!nrst)
        (!busTimeoutEnable && !eccEvt && timeoutEvt) |=> !coreReadBusError)
        else $error("disabled timeout reported");
    pci_fault_a: assert property (@(posedge mclk) disable iff (!nrst)
        (initiatorReadBusErrorEnable && |pciReadFault) |=> otherBusError)
        else $error("pci read fault lost");
    ecc_core_a: assert property (@(posedge mclk) disable iff (!nrst)
        (multibitErrorBusEnable && eccEvt && !eccWrite && eccMaster == BEXP_MST_CORE)
        |=> coreReadBusError) else $error("core ecc error lost");
endmodule
`default_nettype wire

//--- tb/bexp_bus_model.sv
// Model of the bus masters and checkers that report bus faults
`timescale 1ns/1ps
`default_nettype none
module bexp_bus_model
    import bexp_pkg::*;
(
    // Clock
    input  wire logic    mclk,
    // Fault events towards the unit
    output bexp_master_t timeoutMaster,
    output bexp_master_t eccMaster,
    output logic         timeoutEvt,
    output logic         timeoutWrite,
    output logic         eccEvt,
    output logic         eccWrite,
    output logic [4:0]   pciReadFault
);
    // Quiet bus: events low, no fault reported
    initial
    begin
        timeoutEvt = 1'b0;
        eccEvt = 1'b0;
        timeoutWrite = 1'b0;
        eccWrite = 1'b0;
        timeoutMaster = BEXP_MST_CORE;
        eccMaster = BEXP_MST_CORE;
        pciReadFault = 5'h00;
    end
    // One-cycle timeout; qualifiers flip after so stale values never match
    task automatic tmo(input logic w, input bexp_master_t m);
        @(negedge mclk);
        timeoutEvt = 1'b1;
        timeoutWrite = w;
        timeoutMaster = m;
        @(negedge mclk);
        timeoutEvt = 1'b0;
        timeoutWrite = ~w;
        timeoutMaster = bexp_master_t'(~m);
    endtask
    // One-cycle 2-bit ECC or parity fault
    task automatic ecc(input logic w, input bexp_master_t m);
        @(negedge mclk);
        eccEvt = 1'b1;
        eccWrite = w;
        eccMaster = m;
        @(negedge mclk);
        eccEvt = 1'b0;
        eccWrite = ~w;
        eccMaster = bexp_master_t'(~m);
    endtask
    // One-cycle PCI initiator read fault pattern
    task automatic pci(input logic [4:0] f);
        @(negedge mclk);
        pciReadFault = f;
        @(negedge mclk);
        pciReadFault = 5'h00;
    endtask
endmodule
`default_nettype wire

//--- tb/testbench.sv
// Self-checking bench of the exception priority and bus error unit
`timescale 1ns/1ps
`default_nettype none
module testbench
    import bexp_pkg::*;
;
    logic         mclk = 1'b0;
    logic         nrst = 1'b0;
    logic [2:0]   en = 3'h1;
    logic         enableWrite = 1'b0;
    logic [15:0]  excReq = 16'h0000;
    logic         loadIssue = 1'b0;
    logic         loadDataReturn = 1'b0;
    logic         nextDependsOnLoad = 1'b0;
    logic         syncAfterLoad = 1'b0;
    logic         timeoutEvt, timeoutWrite, eccEvt, eccWrite;
    bexp_master_t timeoutMaster, eccMaster;
    logic [4:0]   pciReadFault;
    logic         excValid, excAsync, dataBusErrorDropped, pipeStall, sysBusError;
    bexp_code_t   excCode;
    logic [7:0]   expQ[$];
    int           bad_count = 0;
    int           check_count = 0;
    int           seed = 97;
    int           i;
    // ==========================================================
    // Clock, unit and far side
    always #4 mclk = ~mclk;
    bexp_unit uut (.mclk(mclk), .nrst(nrst), .busTimeoutEnable(en[2]),
        .multibitErrorBusEnable(en[1]), .initiatorReadBusErrorEnable(en[0]),
        .enableWrite(enableWrite), .excReq(excReq), .loadIssue(loadIssue),
        .loadDataReturn(loadDataReturn), .nextDependsOnLoad(nextDependsOnLoad),
        .syncAfterLoad(syncAfterLoad), .timeoutEvt(timeoutEvt),
        .timeoutWrite(timeoutWrite), .timeoutMaster(timeoutMaster), .eccEvt(eccEvt),
        .eccWrite(eccWrite), .eccMaster(eccMaster), .pciReadFault(pciReadFault),
        .excValid(excValid), .excCode(excCode), .excAsync(excAsync),
        .dataBusErrorDropped(dataBusErrorDropped), .pipeStall(pipeStall),
        .sysBusError(sysBusError));
    bexp_bus_model bm (.mclk(mclk), .timeoutMaster(timeoutMaster),
        .eccMaster(eccMaster), .timeoutEvt(timeoutEvt), .timeoutWrite(timeoutWrite),
        .eccEvt(eccEvt), .eccWrite(eccWrite), .pciReadFault(pciReadFault));
    // ==========================================================
    // Helpers
    task automatic tick(input int n = 1);
        repeat (n) @(negedge mclk);
    endtask
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        check_count++;
        if (seen !== exp)
        begin
            bad_count++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    // Note of valid, code, async, dropped, system error
    task automatic note(input logic v, input bexp_code_t c, input logic d, input logic s);
        expQ.push_back({v, c, v & BEXP_ASYNC_MASK[c], d, s});
    endtask
    // Enables are latched; the inputs flip after so only the latch counts
    task automatic setEn(input logic [2:0] v);
        en = v;
        enableWrite = 1'b1;
        tick();
        enableWrite = 1'b0;
        en = ~v;
        tick();
    endtask
    task automatic summarize();
        if (expQ.size() != 0)
            bad_count++;
        $display("Checks %0d, mismatches %0d", check_count, bad_count);
        if (bad_count == 0 && check_count > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    // Each result takes the oldest note; a result nobody asked for meets zero
    always @(negedge mclk)
        if (nrst && ({excValid, sysBusError, dataBusErrorDropped} !== 3'h0))
            check({excValid, excCode, excAsync, dataBusErrorDropped, sysBusError},
                  (expQ.size() == 0) ? 8'h00 : expQ.pop_front());
    // Watchdog, far beyond the few hundred cycles the run needs
    initial
    begin
        tick(3000);
        bad_count++;
        summarize();
    end
    // ==========================================================
    // Scenarios
    initial
    begin
        tick(20);
        nrst = 1'b1;
        // Reset enables: timeouts and ECC silent, PCI read faults reported
        bm.tmo(1'b0, BEXP_MST_DMA);
        bm.ecc(1'b1, BEXP_MST_DMA);
        tick(4);
        note(1'b0, BEXP_NONE, 1'b0, 1'b1);
        bm.pci(5'h04);
        tick(4);
        // Each source beats all lower ones, random lower requests ride along
        for (i = 0; i < 15; i++)
        begin
            excReq = (16'($random(seed)) & ~((16'h0001 << i) - 16'h0001))
                     | (16'h0001 << i);
            // A data bus error riding below a higher winner is reported as lost
            note(1'b1, bexp_code_t'(i), excReq[10] && (i != 10), 1'b0);
            tick();
        end
        // NMI and a data bus error together: NMI wins, the error is dropped
        excReq = 16'h0404;
        note(1'b1, BEXP_NMI, 1'b1, 1'b0);
        tick();
        excReq = 16'h0000;
        tick(4);
        setEn(3'h7);
        // Non-core masters: timeouts and ECC faults on reads and writes
        for (i = 0; i < 6; i++)
        begin
            note(1'b0, BEXP_NONE, 1'b0, 1'b1);
            bm.tmo(i > 2, bexp_master_t'(i % 3 + 1));
            tick(4);
            note(1'b0, BEXP_NONE, 1'b0, 1'b1);
            bm.ecc(i > 2, bexp_master_t'(i % 3 + 1));
            tick(4);
        end
        bm.tmo(1'b1, BEXP_MST_CORE);
        tick(4);
        for (i = 0; i < 5; i++)
        begin
            note(1'b0, BEXP_NONE, 1'b0, 1'b1);
            bm.pci(5'h01 << i);
            tick(4);
        end
        // Core read faults during a pending load become a data bus error
        loadIssue = 1'b1;
        tick();
        loadIssue = 1'b0;
        note(1'b1, BEXP_DATA_BUS_ERROR, 1'b0, 1'b0);
        bm.tmo(1'b0, BEXP_MST_CORE);
        tick(4);
        note(1'b1, BEXP_DATA_BUS_ERROR, 1'b0, 1'b0);
        bm.ecc(1'b0, BEXP_MST_CORE);
        tick(4);
        // A higher exception one cycle later hides the data bus error
        note(1'b1, BEXP_LOAD_ADDRESS_ERROR, 1'b1, 1'b0);
        fork
            bm.ecc(1'b0, BEXP_MST_CORE);
            begin
                tick(2);
                excReq = 16'h0020;
                tick();
                excReq = 16'h0000;
            end
        join
        tick(4);
        loadDataReturn = 1'b1;
        tick();
        loadDataReturn = 1'b0;
        setEn(3'h6);
        bm.pci(5'h1f);
        tick(4);
        // Independent work runs on; a dependent one or a one-cycle sync waits
        for (i = 0; i < 3; i++)
        begin
            loadIssue = 1'b1;
            tick();
            loadIssue = 1'b0;
            nextDependsOnLoad = (i == 1);
            syncAfterLoad = (i == 2);
            tick();
            syncAfterLoad = 1'b0;
            tick(3);
            check(8'(pipeStall), 8'(i != 0));
            nextDependsOnLoad = 1'b0;
            loadDataReturn = 1'b1;
            tick();
            loadDataReturn = 1'b0;
            tick(2);
            check(8'(pipeStall), 8'h00);
        end
        tick(4);
        summarize();
    end
endmodule
`default_nettype wire
